// ==== rtl/power_budget_switch_status_regs.sv ====
/*
 * Power budget capability registers and switch status register.
 * Assumes an Avalon-MM master on clk_sys, fundamental reset on rst and
 * hot reset as a synchronous pulse on hot_rst.
 */
// The Avalon-MM interface to the registers is this design's own decision.
`timescale 1ns/100ps
module power_budget_switch_status_regs
	import pwr_budget_pkg::*;
(
	// Clock and fundamental reset
	input  wire logic        clk_sys,
	input  wire logic        rst,
	// Hot reset, synchronous to clk_sys
	input  wire logic        hot_rst,
	// Avalon-MM slave
	input  wire logic [11:0] address,
	input  wire logic        read,
	input  wire logic        write,
	input  wire logic [31:0] writedata,
	input  wire logic [3:0]  byteenable,
	output logic      [31:0] readdata,
	output logic             waitrequest,
	// Pins
	input  wire logic [2:0]  operating_mode_pins,
	input  wire logic        downstream_common_clock_strap,
	input  wire logic        upstream_common_clock_strap,
	input  wire logic        reset_halt_strap,
	input  wire logic [2:0]  upstream_lock_state,
	// Control levels for the rest of the switch
	output logic             register_unlock_control,
	output logic             data_value_unlock,
	output logic             system_allocated_flag
);

	/**********************************************************************
	 * Pin synchronisation
	 **********************************************************************/
	pin_state_type pins_raw;
	pin_state_type pins_sync;

	always_comb begin
		pins_raw.mode     = operating_mode_pins;
		pins_raw.cclk_ds  = downstream_common_clock_strap;
		pins_raw.cclk_us  = upstream_common_clock_strap;
		pins_raw.rst_halt = reset_halt_strap;
		pins_raw.lock     = upstream_lock_state;
	end

	strap_sync #(
		.WIDTH ($bits(pin_state_type))
	) u_sync (
		.clk_sys (clk_sys),
		.rst     (rst),
		.pin_in  (pins_raw),
		.pin_out (pins_sync)
	);

	/**********************************************************************
	 * Bus request decode
	 **********************************************************************/
	bus_req_type req;
	logic        ack_q;
	logic        in_values;
	logic [3:0]  value_idx;
	logic [31:0] be_mask;
	logic        wr_fire;

	always_comb begin
		req.rd    = read;
		req.wr    = write;
		req.addr  = address;
		req.wdata = writedata;
		req.be    = byteenable;
	end

	// Each access is answered one cycle after it appears.
	assign wr_fire   = req.wr && ack_q;
	assign in_values = (req.addr >= OFS_VALUE_BASE)
		&& (req.addr < OFS_VALUE_BASE + 12'(4 * VALUE_COUNT))
		&& (req.addr[1:0] == 2'b00);
	assign value_idx = 4'((req.addr - OFS_VALUE_BASE) >> 2);
	assign be_mask   = {{8{req.be[3]}}, {8{req.be[2]}}, {8{req.be[1]}}, {8{req.be[0]}}};

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			ack_q <= 1'b0;
		end else begin
			ack_q <= (req.rd || req.wr) && !ack_q;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			waitrequest <= 1'b1;
		end else begin
			waitrequest <= !((req.rd || req.wr) && !ack_q);
		end
	end

	/**********************************************************************
	 * Switch control unlock bits
	 **********************************************************************/
	// The register unlock is set during reset so the loader can write fields.
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			register_unlock_control <= 1'b1;
		end else if (wr_fire && req.addr == OFS_SWITCH_CTRL && req.be[0]) begin
			register_unlock_control <= req.wdata[CTL_REG_UNLOCK];
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			data_value_unlock <= 1'b0;
		end else if (wr_fire && req.addr == OFS_SWITCH_CTRL && req.be[0]
				&& register_unlock_control) begin
			data_value_unlock <= req.wdata[CTL_VALUE_UNLOCK];
		end
	end

	/**********************************************************************
	 * Power budget select, flag and values
	 **********************************************************************/
	logic [SEL_W-1:0] value_select_field;
	logic [31:0]      budget_data_value [VALUE_COUNT];
	logic [31:0]      selected_budget_value;

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			value_select_field <= '0;
		end else if (wr_fire && req.addr == OFS_DATA_SELECT && req.be[0]) begin
			value_select_field <= req.wdata[SEL_W-1:0];
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			system_allocated_flag <= 1'b0;
		end else if (wr_fire && req.addr == OFS_CAP_FLAGS && req.be[0]
				&& register_unlock_control) begin
			system_allocated_flag <= req.wdata[CAP_SA_BIT];
		end
	end

	// The stored values have no defined reset; only the loader or software sets them.
	genvar gi;
	generate
		for (gi = 0; gi < VALUE_COUNT; gi++) begin : g_value
			always_ff @(posedge clk_sys) begin
				if (wr_fire && in_values && value_idx == 4'(gi)
						&& data_value_unlock) begin
					budget_data_value[gi] <= (budget_data_value[gi] & ~be_mask)
						| (req.wdata & be_mask);
				end
			end
		end
	endgenerate

	always_comb begin
		if (value_select_field > SEL_MAX) begin
			selected_budget_value = RST_VALUE;
		end else begin
			selected_budget_value = budget_data_value[value_select_field[3:0]];
		end
	end

	/**********************************************************************
	 * Switch status
	 **********************************************************************/
	logic [2:0] mode_q;
	logic       cclk_ds_q;
	logic       cclk_us_q;
	logic       rst_halt_q;
	logic [1:0] strap_cnt_q;
	logic [3:0] marker_q;

	// The synchroniser is cleared by fundamental reset, so the strap levels only
	// reach pins_sync two clocks after release; they are caught on the clock after.
	// Software must not rely on the status word before that third clock.
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			strap_cnt_q <= '0;
		end else if (strap_cnt_q != STRAP_DONE) begin
			strap_cnt_q <= strap_cnt_q + 2'h1;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			mode_q     <= '0;
			cclk_ds_q  <= 1'b0;
			cclk_us_q  <= 1'b0;
			rst_halt_q <= 1'b0;
		end else if (strap_cnt_q == STRAP_CATCH) begin
			mode_q     <= pins_sync.mode;
			cclk_ds_q  <= pins_sync.cclk_ds;
			cclk_us_q  <= pins_sync.cclk_us;
			rst_halt_q <= pins_sync.rst_halt;
		end
	end

	// Hot reset does not touch the marker; only fundamental reset clears it.
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			marker_q <= RST_MARKER;
		end else if (wr_fire && req.addr == OFS_SWITCH_STATUS && req.be[3]
				&& register_unlock_control) begin
			marker_q <= req.wdata[ST_MARKER_LO +: 4];
		end
	end

	logic [31:0] status_word;

	always_comb begin
		status_word                      = '0;
		status_word[ST_MODE_LO +: 3]     = mode_q;
		status_word[ST_CCLK_DS]          = cclk_ds_q;
		status_word[ST_CCLK_US]          = cclk_us_q;
		status_word[ST_RST_HALT]         = rst_halt_q;
		status_word[ST_LOCK_LO +: 3]     = pins_sync.lock;
		status_word[ST_MARKER_LO +: 4]   = marker_q;
	end

	/**********************************************************************
	 * Read data
	 **********************************************************************/
	logic [31:0] rdata_d;

	always_comb begin
		rdata_d = UNMAPPED_DATA;
		if (in_values) begin
			rdata_d = budget_data_value[value_idx];
		end else begin
			case (req.addr)
				OFS_DATA_SELECT:   rdata_d = {24'h000000, value_select_field};
				OFS_DATA_WINDOW:   rdata_d = selected_budget_value;
				OFS_CAP_FLAGS:     rdata_d = {31'h0, system_allocated_flag};
				OFS_SWITCH_STATUS: rdata_d = status_word;
				OFS_SWITCH_CTRL:   rdata_d = {27'h0, data_value_unlock,
					register_unlock_control, 3'h0};
				default:           rdata_d = UNMAPPED_DATA;
			endcase
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			readdata <= '0;
		end else if (req.rd && !ack_q) begin
			readdata <= rdata_d;
		end
	end

	/**********************************************************************
	 * Checks
	 **********************************************************************/
	property p_window_zero;
		@(posedge clk_sys) disable iff (rst)
		(read && !ack_q && address == OFS_DATA_WINDOW && value_select_field > SEL_MAX)
		|=> readdata == 32'h0;
	endproperty
	a_window_zero: assert property (p_window_zero) else $error("window not zero");

	property p_window_sel;
		@(posedge clk_sys) disable iff (rst)
		(read && !ack_q && address == OFS_DATA_WINDOW && value_select_field <= SEL_MAX)
		|=> readdata == $past(budget_data_value[value_select_field[3:0]]);
	endproperty
	a_window_sel: assert property (p_window_sel) else $error("window wrong");

	property p_window_ro;
		@(posedge clk_sys) disable iff (rst)
		(wr_fire && address == OFS_DATA_WINDOW) |=> $stable(value_select_field)
			&& $stable(system_allocated_flag) && $stable(marker_q);
	endproperty
	a_window_ro: assert property (p_window_ro) else $error("window write had effect");

	property p_value_locked;
		@(posedge clk_sys) disable iff (rst)
		(wr_fire && in_values && !data_value_unlock)
		|=> budget_data_value[$past(value_idx)] == $past(budget_data_value[value_idx]);
	endproperty
	a_value_locked: assert property (p_value_locked) else $error("locked value changed");

	property p_sa_locked;
		@(posedge clk_sys) disable iff (rst)
		!register_unlock_control ##1 !register_unlock_control |-> $stable(system_allocated_flag);
	endproperty
	a_sa_locked: assert property (p_sa_locked) else $error("flag changed while locked");

	property p_marker_hot;
		@(posedge clk_sys) disable iff (rst)
		(hot_rst && !wr_fire) |=> $stable(marker_q);
	endproperty
	a_marker_hot: assert property (p_marker_hot) else $error("marker lost on hot reset");

	property p_status_fields;
		@(posedge clk_sys) disable iff (rst)
		(read && !ack_q && address == OFS_SWITCH_STATUS)
		|=> readdata[ST_LOCK_LO +: 3] == $past(pins_sync.lock)
			&& readdata[ST_RST_HALT] == rst_halt_q && readdata[27:23] == 5'h00;
	endproperty
	a_status_fields: assert property (p_status_fields) else $error("status fields wrong");

	property p_straps_hold;
		@(posedge clk_sys) disable iff (rst)
		strap_cnt_q == STRAP_DONE |=> $stable(cclk_ds_q) && $stable(cclk_us_q)
			&& $stable(mode_q) && $stable(rst_halt_q);
	endproperty
	a_straps_hold: assert property (p_straps_hold) else $error("strap changed");

	property p_straps_taken;
		@(posedge clk_sys) disable iff (rst)
		strap_cnt_q == STRAP_CATCH |=> mode_q == $past(pins_sync.mode)
			&& cclk_us_q == $past(pins_sync.cclk_us)
			&& rst_halt_q == $past(pins_sync.rst_halt);
	endproperty
	a_straps_taken: assert property (p_straps_taken) else $error("strap not caught");

	property p_status_mode;
		@(posedge clk_sys) disable iff (rst)
		(read && !ack_q && address == OFS_SWITCH_STATUS)
		|=> readdata[ST_MODE_LO +: 3] == $past(mode_q) && readdata[ST_CCLK_US] == $past(cclk_us_q);
	endproperty
	a_status_mode: assert property (p_status_mode) else $error("mode field wrong");

	property p_marker_locked;
		@(posedge clk_sys) disable iff (rst)
		(wr_fire && address == OFS_SWITCH_STATUS && !register_unlock_control) |=> $stable(marker_q);
	endproperty
	a_marker_locked: assert property (p_marker_locked) else $error("marker written while locked");

	property p_answer_once;
		@(posedge clk_sys) disable iff (rst)
		!waitrequest |=> waitrequest;
	endproperty
	a_answer_once: assert property (p_answer_once) else $error("answer held too long");

	property p_select_reserved;
		@(posedge clk_sys) disable iff (rst)
		(read && !ack_q && address == OFS_DATA_SELECT) |=> readdata[31:8] == 24'h0;
	endproperty
	a_select_reserved: assert property (p_select_reserved) else $error("reserved set");

	property p_unlock_value;
		@(posedge clk_sys) disable iff (rst)
		(wr_fire && address == OFS_SWITCH_CTRL && byteenable[0] && register_unlock_control)
		|=> data_value_unlock == $past(writedata[CTL_VALUE_UNLOCK]);
	endproperty
	a_unlock_value: assert property (p_unlock_value) else $error("unlock not taken");

endmodule

// ==== rtl/pwr_budget_pkg.sv ====
/*
 * Constants and carrier types for the power budget and switch status bank.
 * Assumes a single 100 MHz core clock and a 32-bit Avalon-MM register bus.
 */
// Summary of operation
// - Eight-bit select field picks which data value register the window shows.
// - Select above nine makes the window read zero.
// - Window is 32-bit read-only; writes to it are ignored.
// - Bit 0 of capability flags is a sticky system-allocated flag.
// - Data value registers accept writes only while the value unlock is set.
// - Status bits 2:0 hold the operating mode pins caught at fundamental reset.
// - Status bit 5 holds the downstream common clock strap caught at fundamental reset.
// - Status bit 6 holds the upstream common clock strap caught at fundamental reset.
// - Status bit 9 holds the reset-halt strap caught at fundamental reset.
// - Status bits 22:20 show the upstream lock state.
// - Four-bit sticky marker in bits 31:28 survives hot reset.
// - Switch control bit 4 unlocks the data value registers.
// - Switch control bit 3 clear makes write-when-unlocked fields read-only.
package pwr_budget_pkg;

	localparam int          ADDR_W            = 12;
	localparam int          VALUE_COUNT       = 10;
	localparam logic [11:0] OFS_DATA_SELECT   = 12'h284;
	localparam logic [11:0] OFS_DATA_WINDOW   = 12'h288;
	localparam logic [11:0] OFS_CAP_FLAGS     = 12'h28c;
	localparam logic [11:0] OFS_VALUE_BASE    = 12'h300;
	localparam logic [11:0] OFS_SWITCH_STATUS = 12'h328;
	localparam logic [11:0] OFS_SWITCH_CTRL   = 12'h32c;

	localparam int          SEL_W             = 8;
	localparam logic [7:0]  SEL_MAX           = 8'h09;
	localparam int          CAP_SA_BIT        = 0;
	localparam int          CTL_REG_UNLOCK    = 3;
	localparam int          CTL_VALUE_UNLOCK  = 4;
	localparam int          ST_MODE_LO        = 0;
	localparam int          ST_CCLK_DS        = 5;
	localparam int          ST_CCLK_US        = 6;
	localparam int          ST_RST_HALT       = 9;
	localparam int          ST_LOCK_LO        = 20;
	localparam int          ST_MARKER_LO      = 28;
	localparam logic [1:0]  STRAP_CATCH       = 2'h2;
	localparam logic [1:0]  STRAP_DONE        = 2'h3;
	localparam logic [31:0] RST_VALUE         = 32'h0000_0000;
	localparam logic [3:0]  RST_MARKER        = 4'h0;
	localparam logic [31:0] UNMAPPED_DATA     = 32'h0000_0000;

	typedef struct packed {
		logic [2:0] mode;
		logic       cclk_ds;
		logic       cclk_us;
		logic       rst_halt;
		logic [2:0] lock;
	} pin_state_type;

	typedef struct packed {
		logic        rd;
		logic        wr;
		logic [11:0] addr;
		logic [31:0] wdata;
		logic [3:0]  be;
	} bus_req_type;

endpackage

// ==== rtl/strap_sync.sv ====
/*
 * Two-flop synchroniser for a group of pin levels.
 * Assumes the pins are asynchronous to clk_sys.
 */
`timescale 1ns/100ps
module strap_sync #(
	parameter int WIDTH = 9
) (
	// Clock and reset
	input  wire logic             clk_sys,
	input  wire logic             rst,
	// Levels
	input  wire logic [WIDTH-1:0] pin_in,
	output logic      [WIDTH-1:0] pin_out
);

	logic [WIDTH-1:0] meta_q;

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			meta_q  <= '0;
			pin_out <= '0;
		end else begin
			meta_q  <= pin_in;
			pin_out <= meta_q;
		end
	end

endmodule

// ==== tb/tb.sv ====
/*
 * Self-checking bench for the power budget and switch status register bank.
 * Assumes the design's own assertions run beside it and that only software
 * stands on the far side, so the bench drives every port itself.
 */
`timescale 1ns/100ps
module tb
	import pwr_budget_pkg::*;
;
	logic          clk_sys   = 1'b0;
	logic          rst       = 1'b1;
	logic          hot_rst   = 1'b0;
	logic          read      = 1'b0;
	logic          write     = 1'b0;
	logic [11:0]   address   = 12'h000;
	logic [31:0]   writedata = 32'h0;
	logic [3:0]    byteenable = 4'h0;
	logic [31:0]   readdata;
	logic          waitrequest;
	logic          register_unlock_control;
	logic          data_value_unlock;
	logic          system_allocated_flag;
	pin_state_type pins      = '0;
	logic [31:0]   exp_val [VALUE_COUNT];
	logic [31:0]   exp_q [$];
	logic [31:0]   d;
	logic [2:0]    lk [3]    = '{3'h0, 3'h2, 3'h3};
	int            err_total = 0;
	int            checked   = 0;
	int            seed      = 32'h3c92ba4c;

	always #5 clk_sys = ~clk_sys;

	power_budget_switch_status_regs u_power_budget_switch_status_regs (
		.clk_sys(clk_sys), .rst(rst), .hot_rst(hot_rst), .address(address), .read(read),
		.write(write), .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
		.waitrequest(waitrequest), .operating_mode_pins(pins.mode),
		.downstream_common_clock_strap(pins.cclk_ds),
		.upstream_common_clock_strap(pins.cclk_us), .reset_halt_strap(pins.rst_halt),
		.upstream_lock_state(pins.lock), .register_unlock_control(register_unlock_control),
		.data_value_unlock(data_value_unlock), .system_allocated_flag(system_allocated_flag)
	);

	// ****************************************************************
	// Bus tasks and checks
	// ****************************************************************
	task automatic fail(input string m);
		err_total++;
		$display("Error at %0t: %s", $time, m);
	endtask

	task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
		checked++;
		if (g !== e) fail(m);
	endtask

	// The request is held until waitrequest is seen low, then one idle edge follows.
	task automatic xfer(input logic rd, input logic [11:0] a, input logic [31:0] wd,
	                    input logic [3:0] b);
		int n;
		read <= rd;
		write <= !rd;
		address <= a;
		writedata <= wd;
		byteenable <= b;
		n = 0;
		do begin
			@(posedge clk_sys);
			n++;
		end while (waitrequest !== 1'b0 && n < 50);
		if (n >= 50) fail("no answer on the bus");
		read <= 1'b0;
		write <= 1'b0;
		@(posedge clk_sys);
	endtask

	task automatic rd(input logic [11:0] a, input logic [31:0] e);
		exp_q.push_back(e);
		xfer(1'b1, a, 32'h0, 4'hf);
	endtask

	task automatic wr(input logic [11:0] a, input logic [31:0] wd, input logic [3:0] b);
		xfer(1'b0, a, wd, b);
	endtask

	// Oldest expectation is compared at the edge where read data stand.
	always @(posedge clk_sys) begin
		if (read === 1'b1 && waitrequest === 1'b0) begin
			if (exp_q.size() == 0) fail("read data with no expectation");
			else chk(readdata, exp_q.pop_front(), "read data mismatch");
		end
	end

	function automatic logic [31:0] st(input logic [3:0] mk);
		return {mk, 5'h0, pins.lock, 10'h0, pins.rst_halt, 2'h0, pins.cclk_us,
		        pins.cclk_ds, 2'h0, pins.mode};
	endfunction

	task automatic do_reset(input pin_state_type p);
		rst <= 1'b1;
		pins <= p;
		repeat (5) @(posedge clk_sys);
		rst <= 1'b0;
		// Straps need three clocks after release to reach the status word.
		repeat (3) @(posedge clk_sys);
	endtask

	task automatic tally_and_finish;
		$display("Comparisons %0d, mismatches %0d", checked, err_total);
		if (err_total == 0 && checked > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	initial begin
		repeat (20000) @(posedge clk_sys);
		fail("watchdog expired");
		tally_and_finish;
	end

	// ****************************************************************
	// Main sequence
	// ****************************************************************
	initial begin
		do_reset({3'h1, 1'b1, 1'b0, 1'b1, 3'h2});
		chk({31'h0, register_unlock_control}, 32'h1, "unlock after reset");
		chk({31'h0, data_value_unlock}, 32'h0, "value unlock after reset");
		chk({31'h0, system_allocated_flag}, 32'h0, "flag after reset");
		rd(OFS_SWITCH_STATUS, st(4'h0));
		rd(OFS_DATA_SELECT, 32'h0);
		rd(OFS_CAP_FLAGS, 32'h0);
		rd(OFS_SWITCH_CTRL, 32'h8);
		do_reset({3'h0, 1'b0, 1'b1, 1'b0, 3'h0});
		rd(OFS_SWITCH_STATUS, st(4'h0));
		foreach (lk[i]) begin
			pins.lock <= lk[i];
			repeat (4) @(posedge clk_sys);
			rd(OFS_SWITCH_STATUS, st(4'h0));
		end
		$display("test reset, straps and lock state done");
		wr(OFS_SWITCH_CTRL, 32'h18, 4'h1);
		chk({31'h0, data_value_unlock}, 32'h1, "value unlock set");
		for (int i = 0; i < VALUE_COUNT; i++) begin
			exp_val[i] = $random(seed);
			wr(OFS_VALUE_BASE + 12'(4 * i), exp_val[i], 4'hf);
			rd(OFS_VALUE_BASE + 12'(4 * i), exp_val[i]);
		end
		for (int i = 0; i < 12; i++) begin
			wr(OFS_DATA_SELECT, 32'(i), 4'h1);
			rd(OFS_DATA_WINDOW, (i <= 9) ? exp_val[i] : 32'h0);
		end
		wr(OFS_DATA_SELECT, 32'hffff_ff05, 4'hf);
		rd(OFS_DATA_SELECT, 32'h5);
		wr(OFS_DATA_WINDOW, $random(seed), 4'hf);
		rd(OFS_DATA_WINDOW, exp_val[5]);
		wr(OFS_DATA_SELECT, 32'hff, 4'h1);
		rd(OFS_DATA_WINDOW, 32'h0);
		d = $random(seed);
		wr(OFS_VALUE_BASE + 12'h8, d, 4'h5);
		exp_val[2] = {exp_val[2][31:24], d[23:16], exp_val[2][15:8], d[7:0]};
		rd(OFS_VALUE_BASE + 12'h8, exp_val[2]);
		wr(OFS_SWITCH_CTRL, 32'h8, 4'h1);
		chk({31'h0, data_value_unlock}, 32'h0, "value unlock clear");
		wr(OFS_VALUE_BASE + 12'hc, ~exp_val[3], 4'hf);
		rd(OFS_VALUE_BASE + 12'hc, exp_val[3]);
		$display("test data values and window done");
		wr(OFS_CAP_FLAGS, 32'hffff_ffff, 4'hf);
		rd(OFS_CAP_FLAGS, 32'h1);
		chk({31'h0, system_allocated_flag}, 32'h1, "flag set");
		wr(OFS_SWITCH_STATUS, 32'hafff_ffff, 4'hf);
		rd(OFS_SWITCH_STATUS, st(4'ha));
		hot_rst <= 1'b1;
		@(posedge clk_sys);
		hot_rst <= 1'b0;
		repeat (2) @(posedge clk_sys);
		rd(OFS_SWITCH_STATUS, st(4'ha));
		wr(OFS_SWITCH_CTRL, 32'h0, 4'h1);
		chk({31'h0, register_unlock_control}, 32'h0, "unlock clear");
		wr(OFS_SWITCH_CTRL, 32'h10, 4'h1);
		rd(OFS_SWITCH_CTRL, 32'h0);
		wr(OFS_CAP_FLAGS, 32'h0, 4'hf);
		rd(OFS_CAP_FLAGS, 32'h1);
		wr(OFS_SWITCH_STATUS, 32'h5000_0000, 4'hf);
		rd(OFS_SWITCH_STATUS, st(4'ha));
		wr(12'h400, $random(seed), 4'hf);
		rd(12'h400, UNMAPPED_DATA);
		if (exp_q.size() != 0) fail("reads left unanswered");
		$display("test locks, marker and unmapped done");
		tally_and_finish;
	end
endmodule
